//--- rtl/gpcb_pkg.sv
// gpcb_pkg: constants for the eight-pin port with change interrupt
// assumes AHB-Lite word registers, 200 MHz core clock
// Contract
// R1: eight pins; level, latch, direction registers
// R2: direction one disables driver, pin input
// R3: direction zero drives latch bit out
// R4: latch register reads latched values
// R5: level reads pins; writes update latch
// R6: shared active-low bit 7 enables pull-ups
// R7: output pins never get pull-up
// R8: reset: pull-ups off, direction all ones
// R9: only pins 4..7 inputs compared
// R10: mismatches ORed set change flag bit 0
// R11: enabled change interrupt wakes from sleep
// R12: level access refreshes snapshot, not mem-move
// R13: mismatch keeps setting flag every cycle
// R14: software avoids polling level register
// R15: enable bit 3, priority bit 0
// R16: low-volt program mode kills pin 5 io
// R17: software keeps pin 5 latch low
// R18: pins 0..2 ext irq, 6/7 program pins
// R19: pad gets value, enable, pull-up; sampled
package gpcb_pkg;
   localparam int PINS = 8;
   localparam logic [7:0] OFS_LEVEL   = 8'h00;
   localparam logic [7:0] OFS_LATCH   = 8'h04;
   localparam logic [7:0] OFS_DIR     = 8'h08;
   localparam logic [7:0] OFS_CTRL1   = 8'h0c;
   localparam logic [7:0] OFS_CTRL2   = 8'h10;
   localparam logic [7:0] OFS_CTRL3   = 8'h14;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h18;
   localparam logic [7:0] OFS_IRQ_MSK = 8'h1c;
   localparam logic [7:0] OFS_LVP     = 8'h20;
   localparam int CTRL1_FLAG_BIT = 0;
   localparam int CTRL1_EN_BIT   = 3;
   localparam int CTRL2_PRIO_BIT = 0;
   localparam int CTRL2_PUN_BIT  = 7;
   localparam int PGM_PIN = 5;
   localparam int CHG_LO  = 4;
   localparam logic [7:0] RST_DIR   = 8'hff;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [7:0] RST_CTRL2 = 8'hf5;
   localparam logic [7:0] CTRL2_MASK = 8'hf5;
   localparam logic [7:0] RST_CTRL3 = 8'hc0;
   localparam logic [7:0] CTRL3_MASK = 8'hdb;
   localparam logic [1:0] RST_IRQ   = 2'h0;
   localparam logic       RST_LVP   = 1'b1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage : gpcb_pkg

//--- rtl/gpcb_port.sv
// gpcb_port: eight-pin port, change detect, AHB-Lite register slave
// assumes pads resolve pin level from out/oe_n/pullup; pads are async
`timescale 1ns/10ps
`default_nettype none
module gpcb_port
   import gpcb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic        mem_move,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [7:0]  pin_in,
   output logic      [7:0]  pin_out,
   output logic      [7:0]  pin_oe_n,
   output logic      [7:0]  pin_pullup,
   input  wire logic        sleep_mode,
   output logic             wake,
   output logic             change_irq_hi,
   output logic             change_irq_lo,
   output logic      [2:0]  ext_irq_in,
   output logic             program_clock_pin,
   output logic             program_data_pin,
   output logic             program_mode_pin,
   output logic             irq
);
   // state bundle; snapshot holds pins 7..4 at the last level access that was not a mem-move
   typedef struct packed {
      logic [7:0]  sync1;
      logic [7:0]  sync2;
      logic [7:0]  latch;
      logic [7:0]  dir;
      logic [7:0]  ctrl1;
      logic [7:0]  ctrl2;
      logic [7:0]  ctrl3;
      logic [3:0]  snap;
      logic [1:0]  irq_st;
      logic [1:0]  irq_msk;
      logic        low_volt_program_mode;
      logic        ap_valid;
      logic        ap_write;
      logic        ap_move;
      logic [7:0]  ap_addr;
      logic [31:0] rdata;
   } gpcb_state_t;

   gpcb_state_t st_reg;
   gpcb_state_t st_next;

   logic [3:0] mismatch;
   logic       change;
   logic       chg_prev_reg;
   logic [7:0] wd;
   logic       take;
   logic       lvl_access;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = st_reg.rdata;
   assign wd        = hwdata[7:0];
   assign take      = hsel && hready && (htrans == HTRANS_NONSEQ)
                      && (hsize == HSIZE_WORD);

   // output pins excluded from the comparison
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         mismatch[i] = st_reg.dir[CHG_LO+i] &&
                       (st_reg.sync2[CHG_LO+i] != st_reg.snap[i]); // R9
      end
   end
   assign change = |mismatch; // R10

   // pad side: driver disabled while direction is one
   genvar g;
   generate
      for (g = 0; g < PINS; g++) begin : g_pad // R1
         logic pgm_here;
         assign pgm_here = (g == PGM_PIN) && st_reg.low_volt_program_mode;
         assign pin_oe_n[g] = st_reg.dir[g] || pgm_here;      // R2 R16 R19
         assign pin_out[g]  = st_reg.latch[g];                // R3
         assign pin_pullup[g] = !st_reg.ctrl2[CTRL2_PUN_BIT]  // R6
                                && st_reg.dir[g]              // R7
                                && !pgm_here;                 // R16
      end
   endgenerate

   assign ext_irq_in        = st_reg.sync2[2:0];    // R18
   assign program_clock_pin = st_reg.sync2[6];      // R18
   assign program_data_pin  = st_reg.sync2[7];      // R18
   assign program_mode_pin  = st_reg.sync2[PGM_PIN] && st_reg.low_volt_program_mode;

   always_comb begin
      change_irq_hi = st_reg.ctrl1[CTRL1_FLAG_BIT] &&
                      st_reg.ctrl1[CTRL1_EN_BIT] &&
                      st_reg.ctrl2[CTRL2_PRIO_BIT]; // R15
      change_irq_lo = st_reg.ctrl1[CTRL1_FLAG_BIT] &&
                      st_reg.ctrl1[CTRL1_EN_BIT] &&
                      !st_reg.ctrl2[CTRL2_PRIO_BIT]; // R15
      wake = sleep_mode && st_reg.ctrl1[CTRL1_FLAG_BIT] &&
             st_reg.ctrl1[CTRL1_EN_BIT]; // R11
      irq  = |(st_reg.irq_st & st_reg.irq_msk);
   end

   always_comb begin
      st_next = st_reg;
      st_next.sync1 = pin_in;            // R19
      st_next.sync2 = st_reg.sync1;
      lvl_access = st_reg.ap_valid && (st_reg.ap_addr == OFS_LEVEL)
                   && !st_reg.ap_move;   // R12
      if (take) begin
         st_next.ap_valid = 1'b1;
         st_next.ap_write = hwrite;
         st_next.ap_move  = mem_move;
         st_next.ap_addr  = {haddr[7:2], 2'b00};
      end else if (hready) begin
         st_next.ap_valid = 1'b0;
      end
      // read data for the address just taken
      if (take && !hwrite) begin
         case ({haddr[7:2], 2'b00})
            OFS_LEVEL:   st_next.rdata = {24'h0, st_reg.sync2};  // R5
            OFS_LATCH:   st_next.rdata = {24'h0, st_reg.latch};  // R4
            OFS_DIR:     st_next.rdata = {24'h0, st_reg.dir};
            OFS_CTRL1:   st_next.rdata = {24'h0, st_reg.ctrl1};
            OFS_CTRL2:   st_next.rdata = {24'h0, st_reg.ctrl2};
            OFS_CTRL3:   st_next.rdata = {24'h0, st_reg.ctrl3};
            OFS_IRQ_ST:  st_next.rdata = {30'h0, st_reg.irq_st};
            OFS_IRQ_MSK: st_next.rdata = {30'h0, st_reg.irq_msk};
            OFS_LVP:     st_next.rdata = {31'h0, st_reg.low_volt_program_mode};
            default:     st_next.rdata = 32'h0;
         endcase
      end
      if (st_reg.ap_valid && st_reg.ap_write) begin
         case (st_reg.ap_addr)
            OFS_LEVEL:   st_next.latch = wd;                     // R5
            OFS_LATCH:   st_next.latch = wd;
            OFS_DIR:     st_next.dir   = wd;
            OFS_CTRL1:   st_next.ctrl1 = wd;
            OFS_CTRL2:   st_next.ctrl2 = wd & CTRL2_MASK;
            OFS_CTRL3:   st_next.ctrl3 = wd & CTRL3_MASK;
            OFS_IRQ_ST:  st_next.irq_st = st_reg.irq_st & ~hwdata[1:0];
            OFS_IRQ_MSK: st_next.irq_msk = hwdata[1:0];
            OFS_LVP:     st_next.low_volt_program_mode = hwdata[0];
            default:     st_next.low_volt_program_mode = st_reg.low_volt_program_mode;
         endcase
      end
      // snapshot refresh ends a mismatch
      if (lvl_access) begin
         st_next.snap = st_reg.sync2[7:4]; // R12
      end
      // set wins over software clear while mismatch stands
      if (change) begin
         st_next.ctrl1[CTRL1_FLAG_BIT] = 1'b1; // R13
      end
      if (change) begin
         st_next.irq_st[0] = 1'b1;
      end
      if (change && !chg_prev_reg && sleep_mode) begin
         st_next.irq_st[1] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg <= '0;
         st_reg.latch   <= RST_LATCH;
         st_reg.dir     <= RST_DIR;   // R8
         st_reg.ctrl1   <= RST_CTRL1;
         st_reg.ctrl2   <= RST_CTRL2; // R8
         st_reg.ctrl3   <= RST_CTRL3;
         st_reg.irq_st  <= RST_IRQ;
         st_reg.irq_msk <= RST_IRQ;
         st_reg.low_volt_program_mode     <= RST_LVP;
         chg_prev_reg   <= 1'b0;
      end else begin
         st_reg       <= st_next;
         chg_prev_reg <= change;
      end
   end
endmodule : gpcb_port
`default_nettype wire

//--- testbench/gpcb_pads.sv
// gpcb_pads: board side of the eight pins
// the port's own driver wins over the bench's drive
`timescale 1ns/10ps
`default_nettype none
module gpcb_pads (
   input  wire logic       clk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   input  wire logic [7:0] pin_pullup,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] pin_in
);
   logic [7:0] last;
   always_ff @(posedge clk) last <= pin_in;
   // a floating pin without pull-up toggles so that it never passes for a steady level
   always_comb for (int i = 0; i < 8; i++) pin_in[i] = !pin_oe_n[i] ?
      pin_out[i] : ext_en[i] ? ext_val[i] : pin_pullup[i] | !last[i];
endmodule : gpcb_pads
`default_nettype wire

//--- testbench/gpcb_port_tb.sv
// gpcb_port_tb: register scenarios for gpcb_port over AHB-Lite
// pins resolved by gpcb_pads; hready is fed back from hreadyout
`timescale 1ns/10ps
`default_nettype none
module gpcb_port_tb import gpcb_pkg::*;;
   logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic mem_move = 1'b0, sleep_mode = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = HSIZE_WORD, ext_irq_in;
   logic [7:0]  ext_en = 8'hff, ext_val = 8'h20, pin_in, pin_out;
   logic [7:0]  pin_oe_n, pin_pullup;
   logic hreadyout, hresp, wake, change_irq_hi, change_irq_lo, irq;
   int num_errors = 0, checked = 0;
   gpcb_port gpcb_port_i (.clk, .reset, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .mem_move, .hrdata, .hreadyout,
      .hresp, .pin_in, .pin_out, .pin_oe_n, .pin_pullup, .sleep_mode, .wake,
      .change_irq_hi, .change_irq_lo, .ext_irq_in, .program_clock_pin(),
      .program_data_pin(), .program_mode_pin(), .irq);
   gpcb_pads gpcb_pads_i (.clk, .pin_out, .pin_oe_n, .pin_pullup, .ext_en,
      .ext_val, .pin_in);
   task automatic chk(input string n, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   task automatic rdy();
      int i;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (hreadyout !== 1'b1 && i < 40);
      if (i >= 40) begin
         num_errors++;
         test_done();
      end
   endtask : rdy
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      v = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      #1;
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), v, e);
   endtask : rc
   // board drive changes at an edge; five edges cover sync and flag
   task automatic pins(input logic [7:0] x);
      @(posedge clk);
      ext_en  <= 8'hf0;
      ext_val <= x;
      repeat (5) @(posedge clk);
      #1;
   endtask : pins
   initial begin
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      chk("pullup", pin_pullup, 8'h00);
      rc(OFS_DIR, 32'hff);
      rc(OFS_CTRL2, 32'hf5);
      rc(8'h40, 32'h0);
      wr(OFS_LVP, 32'h0);
      wr(OFS_LATCH, 32'h0a);
      wr(OFS_DIR, 32'hf0);
      pins(8'h90);
      chk("oe_n", pin_oe_n, 8'hf0);
      chk("out", pin_out, 8'h0a);
      rc(OFS_LATCH, 32'h0a);
      rc(OFS_LEVEL, 32'h9a);
      wr(OFS_LEVEL, 32'h05);
      chk("hresp", hresp, 1'b0);
      chk("hready", hreadyout, 1'b1);
      rc(OFS_LATCH, 32'h05);
      wr(OFS_CTRL2, 32'h75);
      pins(8'h90);
      chk("pullup", pin_pullup, 8'hf0);
      wr(OFS_CTRL1, 32'h08);
      wr(OFS_IRQ_ST, 32'h03);
      rc(OFS_CTRL1, 32'h08);
      pins(8'h10);
      chk("irq_hi", change_irq_hi, 1'b1);
      chk("irq_lo", change_irq_lo, 1'b0);
      rc(OFS_CTRL1, 32'h09);
      mem_move <= 1'b1;
      rc(OFS_LEVEL, 32'h15);
      mem_move <= 1'b0;
      wr(OFS_CTRL1, 32'h08);
      rc(OFS_CTRL1, 32'h09);
      wr(OFS_IRQ_MSK, 32'h01);
      chk("irq", irq, 1'b1);
      wr(OFS_IRQ_MSK, 32'h00);
      chk("irq", irq, 1'b0);
      wr(OFS_IRQ_MSK, 32'h01);
      rc(OFS_LEVEL, 32'h15);
      wr(OFS_CTRL1, 32'h08);
      rc(OFS_CTRL1, 32'h08);
      wr(OFS_IRQ_ST, 32'h01);
      chk("irq", irq, 1'b0);
      chk("wake", wake, 1'b0);
      sleep_mode <= 1'b1;
      pins(8'h00);
      chk("wake", wake, 1'b1);
      rc(OFS_IRQ_ST, 32'h03);
      test_done();
   end
endmodule : gpcb_port_tb
bind gpcb_port gpcb_sva gpcb_sva_i (.clk, .reset, .pin_in, .pin_oe_n,
   .pin_pullup, .sleep_mode, .wake, .change_irq_hi, .change_irq_lo,
   .ext_irq_in, .program_clock_pin, .program_data_pin, .program_mode_pin);
`default_nettype wire

//--- testbench/gpcb_sva.sv
// gpcb_sva: port-level checks of gpcb_port
// bound to every gpcb_port from the bench top file
`timescale 1ns/10ps
`default_nettype none
module gpcb_sva (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic [7:0] pin_in,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] pin_pullup,
   input wire logic       sleep_mode,
   input wire logic       wake,
   input wire logic       change_irq_hi,
   input wire logic       change_irq_lo,
   input wire logic [2:0] ext_irq_in,
   input wire logic       program_clock_pin,
   input wire logic       program_data_pin,
   input wire logic       program_mode_pin
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_pullup_off_out: assert property ((pin_pullup & ~pin_oe_n) == 8'h00)
      else $error("pull-up on a driven pin");
   a_reset_all_in: assert property ($fell(reset) |-> pin_oe_n == 8'hff
      && pin_pullup == 8'h00) else $error("reset state of pins wrong");
   a_prio_one_line: assert property (!(change_irq_hi && change_irq_lo))
      else $error("both priority lines high");
   a_wake_in_sleep: assert property (wake |-> sleep_mode
      && (change_irq_hi || change_irq_lo)) else $error("wake without cause");
   a_ext_irq_sync: assert property (!$past(reset) && !$past(reset, 2)
      |-> ext_irq_in == $past(pin_in[2:0], 2)) else $error("ext irq lag");
   a_prog_clk_sync: assert property (!$past(reset) && !$past(reset, 2)
      |-> program_clock_pin == $past(pin_in[6], 2)) else $error("clk lag");
   a_prog_data_sync: assert property (!$past(reset) && !$past(reset, 2)
      |-> program_data_pin == $past(pin_in[7], 2)) else $error("data lag");
   a_pin5_prog: assert property (program_mode_pin |-> pin_oe_n[5]
      && !pin_pullup[5]) else $error("pin 5 used while in program mode");
endmodule : gpcb_sva
`default_nettype wire
